// ==== hw/dsc_pkg.sv ====
// constants and types shared by the debug state sequencer control block
package dsc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] DSC_ADDR_CTRL = 8'h20;
    localparam logic [7:0] DSC_ADDR_STATE_WIN = 8'h27;

    // debug_control_one field positions
    localparam int DSC_CTRL_ARM_BIT = 7;
    localparam int DSC_CTRL_WSEL_LSB = 0;

    // window_select codes
    localparam logic [1:0] DSC_WSEL_STATE1 = 2'h0;
    localparam logic [1:0] DSC_WSEL_STATE2 = 2'h1;
    localparam logic [1:0] DSC_WSEL_STATE3 = 2'h2;
    localparam logic [1:0] DSC_WSEL_FLAGS = 2'h3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] DSC_CODE_RESET = 4'h0;
    localparam logic [2:0] DSC_FLAGS_RESET = 3'h0;
    localparam logic [1:0] DSC_WSEL_RESET = 2'h0;

    localparam int DSC_NUM_CH = 3;
    localparam int DSC_NUM_STATES = 3;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        DSC_IDLE = 5'h01,
        DSC_S1 = 5'h02,
        DSC_S2 = 5'h04,
        DSC_S3 = 5'h08,
        DSC_FINAL = 5'h10
    } dsc_seq_t;

    // one destination per channel; DSC_IDLE means the match is ignored
    typedef dsc_seq_t [DSC_NUM_CH-1:0] dsc_dest_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dsc_bus_req_t;

endpackage

// ==== hw/dsc_sequencer.sv ====
// debug state sequencer with its state control and match flag registers
//
// Overview of operation
// - one byte address; window_select 00/01/10 states 1-3, 11 flags
// - separate next-state control register for each state 1 to 3
// - state-1 control read at select 00, written there when unarmed
// - state-2 control read at select 01, written there when unarmed
// - state-3 control read at select 10, written there when unarmed
// - match flags readable only at select 11, writes ignored
// - state 1 codes 0000 to 0011 per the state-1 table
// - state 1 codes 0100 to 0111, 1001 and 1101 per table
// - a channel match not named by the code causes no transition
// - state 2 codes 0000 to 0101 per the state-2 table
// - state 2 codes 0110, 0111, 1100 and 1111 per table
// - state 3 codes 0000 to 0101 per the state-3 table
// - state 3 codes 0110, 0111, 1010, 1101 and 1110 per table
// - simultaneous matches: final wins, then lowest channel number
// - three flags, one per channel, set on match while armed
// - flags survive session end; cleared only by the next arm
// - flags set independently; repeat matches leave a set flag alone
// - writing one to the arm bit starts a new session
module dsc_sequencer (
    input wire logic ref_clk,
    input wire logic srst,
    input wire dsc_pkg::dsc_bus_req_t bus_req,
    input wire logic [2:0] match_in,
    output logic [7:0] rdata,
    output dsc_pkg::dsc_seq_t seq_state,
    output logic armed,
    output logic session_end
);

    // ------------------------------------------------------------------
    // state-1 next-state decode
    // ------------------------------------------------------------------
    function automatic dsc_pkg::dsc_dest_t dest_s1(input logic [3:0] code);
        dsc_pkg::dsc_dest_t d;
        d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
        case (code)
            4'h0: begin
                d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_FINAL}};
            end
            4'h1: begin
                d[1] = dsc_pkg::DSC_S3;
            end
            4'h2: begin
                d[2] = dsc_pkg::DSC_S2;
            end
            4'h3: begin
                d[1] = dsc_pkg::DSC_S2;
            end
            4'h4: begin
                d[0] = dsc_pkg::DSC_S2;
                d[1] = dsc_pkg::DSC_S3;
            end
            4'h5: begin
                d[1] = dsc_pkg::DSC_S3;
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'h6: begin
                d[0] = dsc_pkg::DSC_S2;
                d[2] = dsc_pkg::DSC_S3;
            end
            4'h7: begin
                d[0] = dsc_pkg::DSC_S2;
                d[1] = dsc_pkg::DSC_S2;
            end
            4'h9: begin
                d[0] = dsc_pkg::DSC_S3;
            end
            4'hd: begin
                d[0] = dsc_pkg::DSC_FINAL;
                d[2] = dsc_pkg::DSC_FINAL;
                d[1] = dsc_pkg::DSC_S2;
            end
            default: begin
                d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // state-2 next-state decode
    // ------------------------------------------------------------------
    function automatic dsc_pkg::dsc_dest_t dest_s2(input logic [3:0] code);
        dsc_pkg::dsc_dest_t d;
        d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
        case (code)
            4'h0: begin
                d[0] = dsc_pkg::DSC_S1;
                d[2] = dsc_pkg::DSC_S3;
            end
            4'h1: begin
                d[1] = dsc_pkg::DSC_S3;
            end
            4'h2: begin
                d[2] = dsc_pkg::DSC_S3;
            end
            4'h3: begin
                d[1] = dsc_pkg::DSC_S3;
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'h4: begin
                d[1] = dsc_pkg::DSC_S1;
                d[2] = dsc_pkg::DSC_S3;
            end
            4'h5: begin
                d[2] = dsc_pkg::DSC_FINAL;
            end
            4'h6: begin
                d[2] = dsc_pkg::DSC_S1;
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'h7: begin
                d[0] = dsc_pkg::DSC_FINAL;
                d[1] = dsc_pkg::DSC_FINAL;
            end
            4'hc: begin
                d[0] = dsc_pkg::DSC_FINAL;
                d[1] = dsc_pkg::DSC_FINAL;
                d[2] = dsc_pkg::DSC_S3;
            end
            4'hf: begin
                d[0] = dsc_pkg::DSC_FINAL;
                d[1] = dsc_pkg::DSC_FINAL;
                d[2] = dsc_pkg::DSC_S1;
            end
            default: begin
                d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // state-3 next-state decode
    // ------------------------------------------------------------------
    function automatic dsc_pkg::dsc_dest_t dest_s3(input logic [3:0] code);
        dsc_pkg::dsc_dest_t d;
        d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
        case (code)
            4'h0: begin
                d[0] = dsc_pkg::DSC_S1;
            end
            4'h1: begin
                d[2] = dsc_pkg::DSC_S2;
                d[1] = dsc_pkg::DSC_FINAL;
            end
            4'h2: begin
                d[0] = dsc_pkg::DSC_FINAL;
                d[1] = dsc_pkg::DSC_S1;
            end
            4'h3: begin
                d[1] = dsc_pkg::DSC_FINAL;
                d[2] = dsc_pkg::DSC_S1;
            end
            4'h4: begin
                d[1] = dsc_pkg::DSC_S2;
            end
            4'h5: begin
                d[1] = dsc_pkg::DSC_FINAL;
            end
            4'h6: begin
                d[2] = dsc_pkg::DSC_S2;
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'h7: begin
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'ha: begin
                d[1] = dsc_pkg::DSC_S1;
                d[2] = dsc_pkg::DSC_S1;
                d[0] = dsc_pkg::DSC_FINAL;
            end
            4'hd: begin
                d[1] = dsc_pkg::DSC_FINAL;
                d[2] = dsc_pkg::DSC_FINAL;
                d[0] = dsc_pkg::DSC_S1;
            end
            4'he: begin
                d[0] = dsc_pkg::DSC_S2;
                d[2] = dsc_pkg::DSC_FINAL;
            end
            default: begin
                d = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
            end
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [3:0] code_reg [dsc_pkg::DSC_NUM_STATES];
    logic [2:0] flags_reg;
    logic [1:0] wsel_reg;
    logic armed_reg;
    dsc_pkg::dsc_seq_t seq_reg;
    dsc_pkg::dsc_seq_t seq_next;
    logic end_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    logic ctrl_wr;
    logic win_wr;
    logic arm_wr;
    logic disarm_wr;
    dsc_pkg::dsc_dest_t dest;
    logic [2:0] hit_final;
    logic [2:0] hit_any;

    assign ctrl_wr = bus_req.wr && (bus_req.addr == dsc_pkg::DSC_ADDR_CTRL);
    assign win_wr = bus_req.wr
        && (bus_req.addr == dsc_pkg::DSC_ADDR_STATE_WIN);
    assign arm_wr = ctrl_wr && bus_req.wdata[dsc_pkg::DSC_CTRL_ARM_BIT];
    assign disarm_wr = ctrl_wr
        && !bus_req.wdata[dsc_pkg::DSC_CTRL_ARM_BIT];

    // ------------------------------------------------------------------
    // control register: arm and window select
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wsel_reg <= dsc_pkg::DSC_WSEL_RESET;
        end else if (ctrl_wr) begin
            wsel_reg <= bus_req.wdata[dsc_pkg::DSC_CTRL_WSEL_LSB +: 2];
        end
    end

    // session ends on reaching final state or on a disarm write
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            armed_reg <= 1'b0;
        end else if (arm_wr) begin
            armed_reg <= 1'b1;
        end else if (disarm_wr || seq_next == dsc_pkg::DSC_FINAL) begin
            armed_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // next-state code registers, locked while armed
    // ------------------------------------------------------------------
    genvar gs;
    generate
        for (gs = 0; gs < dsc_pkg::DSC_NUM_STATES; gs++) begin : g_code
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    code_reg[gs] <= dsc_pkg::DSC_CODE_RESET;
                end else if (win_wr && !armed_reg
                    && wsel_reg == 2'(gs)) begin
                    code_reg[gs] <= bus_req.wdata[3:0];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // per-channel match flags and candidate hits
    // ------------------------------------------------------------------
    genvar gc;
    generate
        for (gc = 0; gc < dsc_pkg::DSC_NUM_CH; gc++) begin : g_ch
            // match_in is assumed gated by the comparator enable
            assign hit_final[gc] = match_in[gc]
                && dest[gc] == dsc_pkg::DSC_FINAL;
            assign hit_any[gc] = match_in[gc]
                && dest[gc] != dsc_pkg::DSC_IDLE;

            // a match while armed outranks the arm-write clear
            always_ff @(posedge ref_clk) begin
                if (srst) begin
                    flags_reg[gc] <= 1'b0;
                end else if (armed_reg && match_in[gc]) begin
                    flags_reg[gc] <= 1'b1;
                end else if (arm_wr) begin
                    flags_reg[gc] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_comb begin
        case (seq_reg)
            dsc_pkg::DSC_S1: dest = dest_s1(code_reg[0]);
            dsc_pkg::DSC_S2: dest = dest_s2(code_reg[1]);
            dsc_pkg::DSC_S3: dest = dest_s3(code_reg[2]);
            default: dest = {dsc_pkg::DSC_NUM_CH{dsc_pkg::DSC_IDLE}};
        endcase
    end

    always_comb begin
        seq_next = seq_reg;
        if (arm_wr) begin
            seq_next = dsc_pkg::DSC_S1;
        end else if (disarm_wr) begin
            seq_next = dsc_pkg::DSC_IDLE;
        end else if (armed_reg) begin
            if (|hit_final) begin
                seq_next = dsc_pkg::DSC_FINAL;
            end else if (hit_any[0]) begin
                seq_next = dest[0];
            end else if (hit_any[1]) begin
                seq_next = dest[1];
            end else if (hit_any[2]) begin
                seq_next = dest[2];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            seq_reg <= dsc_pkg::DSC_IDLE;
        end else begin
            seq_reg <= seq_next;
        end
    end

    // one-cycle pulse on the edge that enters final state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            end_reg <= 1'b0;
        end else begin
            end_reg <= armed_reg && !arm_wr && !disarm_wr
                && seq_next == dsc_pkg::DSC_FINAL;
        end
    end

    // ------------------------------------------------------------------
    // read path: data valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (bus_req.rd) begin
            if (bus_req.addr == dsc_pkg::DSC_ADDR_CTRL) begin
                rdata_next[dsc_pkg::DSC_CTRL_ARM_BIT] = armed_reg;
                rdata_next[dsc_pkg::DSC_CTRL_WSEL_LSB +: 2] = wsel_reg;
            end else if (bus_req.addr == dsc_pkg::DSC_ADDR_STATE_WIN) begin
                case (wsel_reg)
                    dsc_pkg::DSC_WSEL_STATE1: rdata_next[3:0] = code_reg[0];
                    dsc_pkg::DSC_WSEL_STATE2: rdata_next[3:0] = code_reg[1];
                    dsc_pkg::DSC_WSEL_STATE3: rdata_next[3:0] = code_reg[2];
                    default: rdata_next[2:0] = flags_reg;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;
    assign seq_state = seq_reg;
    assign armed = armed_reg;
    assign session_end = end_reg;

endmodule

// ==== tb/dsc_sequencer_monitor.sv ====
// concurrent checks on the ports of the debug state sequencer
module dsc_sequencer_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire dsc_pkg::dsc_bus_req_t bus_req,
    input wire logic [2:0] match_in,
    input wire logic [7:0] rdata,
    input wire dsc_pkg::dsc_seq_t seq_state,
    input wire logic armed,
    input wire logic session_end
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    logic ctrl_wr;
    logic arm_wr;
    assign ctrl_wr = bus_req.wr && bus_req.addr == dsc_pkg::DSC_ADDR_CTRL;
    assign arm_wr = ctrl_wr && bus_req.wdata[dsc_pkg::DSC_CTRL_ARM_BIT];

    // ------------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------------
    a_rdata_quiet: assert property (!bus_req.rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_win_upper: assert property (
        bus_req.rd && bus_req.addr == dsc_pkg::DSC_ADDR_STATE_WIN
        |=> rdata[7:4] == 4'h0)
        else $error("upper window bits not zero");
    a_arm_start: assert property (
        arm_wr && match_in == 3'h0 |=> armed && seq_state == dsc_pkg::DSC_S1)
        else $error("arm write did not start in state one");
    a_no_match_hold: assert property (
        armed && match_in == 3'h0 && !ctrl_wr |=> $stable(seq_state))
        else $error("state moved without a match");
    a_unarmed_still: assert property (
        !armed && !ctrl_wr |=> $stable(seq_state) && !armed)
        else $error("state moved while not armed");
    a_final_ends: assert property (
        armed ##1 seq_state == dsc_pkg::DSC_FINAL |-> !armed && session_end)
        else $error("entering final did not end the session");
    a_end_pulse: assert property (
        session_end |-> (seq_state == dsc_pkg::DSC_FINAL && !armed)
        ##1 !session_end)
        else $error("session end pulse wrong");
    a_armed_legal: assert property (
        armed |-> seq_state inside {dsc_pkg::DSC_S1, dsc_pkg::DSC_S2,
        dsc_pkg::DSC_S3})
        else $error("armed outside the intermediate states");
    a_drop_cause: assert property (
        $fell(armed) |-> seq_state == dsc_pkg::DSC_FINAL || $past(ctrl_wr))
        else $error("armed dropped without cause");

    c_final: cover property (session_end);
    c_to_two: cover property (armed && match_in != 3'h0
        ##1 seq_state == dsc_pkg::DSC_S2);
    c_locked_wr: cover property (bus_req.wr && armed
        && bus_req.addr == dsc_pkg::DSC_ADDR_STATE_WIN);
endmodule

bind dsc_sequencer dsc_sequencer_monitor i_mon (
    .ref_clk(ref_clk),
    .srst(srst),
    .bus_req(bus_req),
    .match_in(match_in),
    .rdata(rdata),
    .seq_state(seq_state),
    .armed(armed),
    .session_end(session_end)
);

// ==== tb/dsc_match_source.sv ====
// comparator channel model feeding registered match events
module dsc_match_source (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [2:0] cmp_en,
    input wire logic [2:0] hit,
    output logic [2:0] match_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // a disabled comparator never reports, whatever it sees
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            match_in <= 3'h0;
        end else begin
            match_in <= hit & cmp_en;
        end
    end
endmodule

// ==== tb/dsc_sequencer_tb.sv ====
// self-checking bench for the debug state sequencer
module dsc_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CTRL = dsc_pkg::DSC_ADDR_CTRL;
    localparam logic [7:0] WIN = dsc_pkg::DSC_ADDR_STATE_WIN;
    // {state, code, match, dest}: dest 0 stays, f is final
    localparam logic [15:0] CASES [55] = '{
        16'h104f, 16'h1123, 16'h1110, 16'h1242, 16'h1322, 16'h1412,
        16'h1423, 16'h1523, 16'h153f, 16'h1612, 16'h1643, 16'h1652,
        16'h1722, 16'h1870, 16'h1913, 16'h1d3f, 16'h1d22, 16'h1e70,
        16'h2011, 16'h2043, 16'h2123, 16'h2243, 16'h231f, 16'h2323,
        16'h2421, 16'h2461, 16'h254f, 16'h2641, 16'h265f, 16'h272f,
        16'h2c43, 16'h2c5f, 16'h2f41, 16'h2f6f, 16'h2870, 16'h3011,
        16'h3142, 16'h316f, 16'h3221, 16'h323f, 16'h3341, 16'h332f,
        16'h3422, 16'h352f, 16'h3642, 16'h365f, 16'h371f, 16'h3760,
        16'h3a61, 16'h3a7f, 16'h3d11, 16'h3d3f, 16'h3e12, 16'h3e4f,
        16'h3b70};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    dsc_pkg::dsc_bus_req_t bus_req = '0;
    logic [2:0] hit = 3'h0;
    logic [2:0] cmp_en = 3'h7;
    logic [2:0] match_in;
    logic [7:0] rdata;
    dsc_pkg::dsc_seq_t seq_state;
    logic armed;
    logic session_end;
    logic [7:0] d;
    int n_mismatch = 0;
    int checked = 0;

    dsc_match_source i_src (.ref_clk(ref_clk), .srst(srst),
        .cmp_en(cmp_en), .hit(hit), .match_in(match_in));
    dsc_sequencer i_dut (.ref_clk(ref_clk), .srst(srst), .bus_req(bus_req),
        .match_in(match_in), .rdata(rdata), .seq_state(seq_state),
        .armed(armed), .session_end(session_end));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // bus, match and compare helpers
    // ------------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
        // step off the edge so callers see what that edge launched
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask
    // partner registers the hit, so the design takes it one edge later
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk);
        hit <= m;
        @(posedge ref_clk);
        hit <= 3'h0;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic cmp_byte(input string n, input logic [7:0] e,
        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_state(input string n, input dsc_pkg::dsc_seq_t e);
        cmp_byte(n, {3'h0, e}, {3'h0, seq_state});
    endtask
    function automatic dsc_pkg::dsc_seq_t to_state(input logic [3:0] n);
        case (n)
            4'h1: return dsc_pkg::DSC_S1;
            4'h2: return dsc_pkg::DSC_S2;
            4'h3: return dsc_pkg::DSC_S3;
            4'hf: return dsc_pkg::DSC_FINAL;
            default: return dsc_pkg::DSC_IDLE;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) begin
            wr(CTRL, 8'(i));
            rd(WIN, d);
            cmp_byte("reset window", 8'h00, d);
        end
        rd(8'h30, d);
        cmp_byte("unmapped", 8'h00, d);
        cmp_state("reset state", dsc_pkg::DSC_IDLE);
        $display("test reset done");
    endtask
    task automatic t_window();
        for (int i = 0; i < 3; i++) begin
            wr(CTRL, 8'(i));
            wr(WIN, 8'hf5 + 8'(i));
        end
        for (int i = 0; i < 3; i++) begin
            wr(CTRL, 8'(i));
            rd(WIN, d);
            cmp_byte("code", 8'h05 + 8'(i), d);
        end
        wr(CTRL, 8'h03);
        wr(WIN, 8'hff);
        rd(WIN, d);
        cmp_byte("flags write", 8'h00, d);
        $display("test window done");
    endtask
    task automatic t_lock();
        wr(CTRL, 8'h81);
        rd(CTRL, d);
        cmp_byte("control armed", 8'h81, d);
        wr(WIN, 8'h0e);
        rd(WIN, d);
        cmp_byte("locked armed", 8'h06, d);
        wr(CTRL, 8'h01);
        rd(CTRL, d);
        cmp_byte("control idle", 8'h01, d);
        rd(WIN, d);
        cmp_byte("locked after", 8'h06, d);
        $display("test lock done");
    endtask
    task automatic run_case(input logic [15:0] c);
        logic [3:0] st;
        logic [3:0] code;
        logic [3:0] m;
        logic [3:0] dn;
        {st, code, m, dn} = c;
        wr(CTRL, 8'h00);
        wr(WIN, st == 4'h1 ? {4'h0, code} : (st == 4'h2 ? 8'h02 : 8'h01));
        wr(CTRL, 8'h01);
        wr(WIN, {4'h0, code});
        wr(CTRL, 8'h02);
        wr(WIN, {4'h0, code});
        wr(CTRL, 8'h80);
        if (st != 4'h1) pulse(st == 4'h2 ? 3'h4 : 3'h2);
        cmp_state("entry", to_state(st));
        pulse(m[2:0]);
        cmp_state("next", to_state(dn == 4'h0 ? st : dn));
        if (dn == 4'hf) cmp_byte("end", 8'h01, {6'h0, armed, session_end});
    endtask
    task automatic t_table();
        foreach (CASES[i]) run_case(CASES[i]);
        $display("test table done");
        wr(CTRL, 8'h00);
    endtask
    task automatic t_enable();
        wr(WIN, 8'h00);
        wr(CTRL, 8'h80);
        cmp_en <= 3'h0;
        pulse(3'h7);
        cmp_state("disabled", dsc_pkg::DSC_S1);
        cmp_en <= 3'h7;
        wr(CTRL, 8'h00);
        $display("test enable done");
    endtask
    task automatic t_flags();
        wr(WIN, 8'h03);
        wr(CTRL, 8'h01);
        wr(WIN, 8'h07);
        wr(CTRL, 8'h83);
        rd(WIN, d);
        cmp_byte("flags armed", 8'h00, d);
        pulse(3'h4);
        pulse(3'h4);
        rd(WIN, d);
        cmp_byte("flag two", 8'h04, d);
        pulse(3'h2);
        pulse(3'h2);
        cmp_state("flags final", dsc_pkg::DSC_FINAL);
        pulse(3'h1);
        cmp_state("final holds", dsc_pkg::DSC_FINAL);
        wr(WIN, 8'hff);
        rd(WIN, d);
        cmp_byte("flags kept", 8'h06, d);
        wr(CTRL, 8'h83);
        rd(WIN, d);
        cmp_byte("flags rearm", 8'h00, d);
        wr(CTRL, 8'h00);
        $display("test flags done");
    endtask

    task automatic final_report();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_window();
        t_lock();
        t_table();
        t_enable();
        t_flags();
        final_report();
    end
    // whole run is near 1160 cycles
    initial begin
        #500us;
        n_mismatch++;
        final_report();
    end
endmodule
